// file: verilog/slc_pkg.sv
// Package with register map, codes and timing for the sleep controller
`default_nettype none
package slc_pkg;
  localparam logic [3:0] SLC_CTRL_OFFSET   = 4'h0;
  localparam int         SLC_SEN_POS       = 0;
  localparam int         SLC_MODE_LSB      = 1;
  localparam logic [7:0] SLC_CTRL_RESET    = 8'h00;
  localparam logic [1:0] SLC_MODE_IDLE     = 2'h0;
  localparam logic [1:0] SLC_MODE_STANDBY  = 2'h1;
  localparam logic [1:0] SLC_MODE_POWER_DOWN_CODE    = 2'h2;
  localparam logic [1:0] SLC_MODE_RESERVED = 2'h3;
  localparam logic [1:0] SLC_BOD_WAIT_CODE = 2'h3;
  localparam logic [2:0] SLC_WAKE_CYCLES   = 3'h6;

  typedef enum logic [1:0] {
    SLC_ACTIVE,
    SLC_ASLEEP,
    SLC_OSC_WAIT,
    SLC_LATENCY
  } slc_state_e;

  // Interrupt requests that are already enabled at their source
  typedef struct packed {
    logic pin;
    logic twi_match;
    logic usart_sof;
    logic adc_window;
    logic rtc;
    logic periodic_interrupt_timer;
    logic type_b_timer;
    logic other;
  } slc_wake_s;

  // Run-in-standby settings of the peripherals
  typedef struct packed {
    logic usart;
    logic adc;
    logic rtc;
  } slc_rsb_s;

  // Clock and oscillator enables
  typedef struct packed {
    logic cpu_clk_en;
    logic per_clk_en;
    logic rtc_clk_en;
    logic adc_clk_en;
    logic pit_clk_en;
    logic wdt_clk_en;
    logic main_osc_en;
    logic rtc_osc_en;
    logic wdt_osc_en;
    logic ulp_osc_en;
  } slc_gate_s;
endpackage
`default_nettype wire

// file: verilog/slc_sleep_controller.sv
// Sleep mode controller with Avalon-MM control register
`default_nettype none
module slc_sleep_controller
  import slc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        sleep_instr,
  input  wire logic        global_irq_en,
  input  wire slc_wake_s   wake_req,
  input  wire slc_rsb_s    run_in_standby,
  input  wire logic        dbg_break,
  input  wire logic [1:0]  brownout_config_fuse,
  input  wire logic        bod_uses_ulp,
  input  wire logic        wdt_uses_ulp,
  input  wire logic        main_osc_ready,
  input  wire logic        brownout_ready,
  output slc_gate_s        gate,
  output logic             sleeping,
  output logic             resume
);
  slc_state_e  state_reg, state_next;
  logic [1:0]  mode_reg, mode_next;
  logic        sen_reg, sen_next;
  logic [1:0]  sleep_mode_select_reg, sleep_mode_select_next;
  logic [2:0]  cnt_reg, cnt_next;
  logic        resume_reg, resume_next;
  slc_gate_s   gate_reg, gate_next;
  logic        ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        osc_meta_reg, osc_sync_reg;
  logic        bod_meta_reg, bod_sync_reg;
  logic        hit;
  logic        irq_ok;
  logic        wake;
  logic        bod_ok;

  // Bus slave: one wait cycle, then answer
  assign hit             = avs_address == SLC_CTRL_OFFSET;
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  always_comb begin
    ack_next   = (avs_read | avs_write) & ~ack_reg;
    rdata_next = rdata_reg;
    sen_next   = sen_reg;
    sleep_mode_select_next = sleep_mode_select_reg;
    if (avs_read & ~ack_reg) begin
      rdata_next = '0;
      if (hit) begin
        rdata_next[SLC_SEN_POS] = sen_reg;
        rdata_next[SLC_MODE_LSB +: 2] = sleep_mode_select_reg;
      end
    end
    if (avs_write & ack_reg & hit & avs_byteenable[0]) begin
      sen_next   = avs_writedata[SLC_SEN_POS];
      sleep_mode_select_next = avs_writedata[SLC_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg   <= 1'b0;
      rdata_reg <= '0;
      sen_reg   <= SLC_CTRL_RESET[SLC_SEN_POS];
      sleep_mode_select_reg <= SLC_CTRL_RESET[SLC_MODE_LSB +: 2];
    end else begin
      ack_reg   <= ack_next;
      rdata_reg <= rdata_next;
      sen_reg   <= sen_next;
      sleep_mode_select_reg <= sleep_mode_select_next;
    end
  end

  // Analog ready levels cross in through two flip-flops
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      osc_meta_reg <= 1'b0;
      osc_sync_reg <= 1'b0;
      bod_meta_reg <= 1'b0;
      bod_sync_reg <= 1'b0;
    end else begin
      osc_meta_reg <= main_osc_ready;
      osc_sync_reg <= osc_meta_reg;
      bod_meta_reg <= brownout_ready;
      bod_sync_reg <= bod_meta_reg;
    end
  end

  // Wake qualification per sleep mode
  always_comb begin
    case (mode_reg)
      SLC_MODE_IDLE: irq_ok = |wake_req;
      SLC_MODE_STANDBY: irq_ok = wake_req.pin | wake_req.twi_match
        | wake_req.type_b_timer | wake_req.periodic_interrupt_timer
        | (wake_req.usart_sof & run_in_standby.usart)
        | (wake_req.adc_window & run_in_standby.adc)
        | (wake_req.rtc & run_in_standby.rtc);
      SLC_MODE_POWER_DOWN_CODE: irq_ok = wake_req.pin | wake_req.twi_match
        | wake_req.periodic_interrupt_timer;
      default: irq_ok = 1'b0;
    endcase
  end

  assign wake   = dbg_break | (global_irq_en & irq_ok);
  assign bod_ok = (brownout_config_fuse != SLC_BOD_WAIT_CODE)
                | bod_sync_reg;

  always_comb begin
    state_next  = state_reg;
    mode_next   = mode_reg;
    cnt_next    = cnt_reg;
    resume_next = 1'b0;
    case (state_reg)
      SLC_ACTIVE: begin
        if (sleep_instr & sen_reg
            & (sleep_mode_select_reg != SLC_MODE_RESERVED)) begin
          state_next = SLC_ASLEEP;
          mode_next  = sleep_mode_select_reg;
        end
      end
      SLC_ASLEEP: begin
        if (wake) begin
          if (mode_reg == SLC_MODE_IDLE) begin
            state_next = SLC_LATENCY;
            cnt_next   = SLC_WAKE_CYCLES - 3'h1;
          end else begin
            state_next = SLC_OSC_WAIT;
          end
        end
      end
      SLC_OSC_WAIT: begin
        if (osc_sync_reg) begin
          state_next = SLC_LATENCY;
          cnt_next   = SLC_WAKE_CYCLES - 3'h1;
        end
      end
      SLC_LATENCY: begin
        if (cnt_reg != 3'h0) begin
          cnt_next = cnt_reg - 3'h1;
        end else if (bod_ok) begin
          state_next  = SLC_ACTIVE;
          resume_next = 1'b1;
        end
      end
      default: state_next = SLC_ACTIVE;
    endcase
  end

  // Gates follow the state being entered
  always_comb begin
    gate_next = '1;
    if (state_next != SLC_ACTIVE) begin
      gate_next.cpu_clk_en = 1'b0;
    end
    if (state_next == SLC_ASLEEP) begin
      case (mode_next)
        SLC_MODE_STANDBY: begin
          gate_next.per_clk_en  = run_in_standby.usart
                                | run_in_standby.adc;
          gate_next.adc_clk_en  = run_in_standby.adc;
          gate_next.rtc_clk_en  = run_in_standby.rtc;
          gate_next.main_osc_en = run_in_standby.usart
                                | run_in_standby.adc;
          gate_next.rtc_osc_en  = run_in_standby.rtc;
        end
        SLC_MODE_POWER_DOWN_CODE: begin
          gate_next.per_clk_en  = 1'b0;
          gate_next.adc_clk_en  = 1'b0;
          gate_next.rtc_clk_en  = 1'b0;
          gate_next.main_osc_en = 1'b0;
          gate_next.rtc_osc_en  = bod_uses_ulp | wdt_uses_ulp;
          gate_next.ulp_osc_en  = bod_uses_ulp | wdt_uses_ulp;
        end
        default: ;
      endcase
    end
  end

  // Gates are registered so that clock enables never glitch on a
  // combinational wake path; the cost is one cycle before they change.
  // Reset from any state restarts in active mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg  <= SLC_ACTIVE;
      mode_reg   <= SLC_MODE_IDLE;
      cnt_reg    <= 3'h0;
      resume_reg <= 1'b0;
      gate_reg   <= '1;
    end else begin
      state_reg  <= state_next;
      mode_reg   <= mode_next;
      cnt_reg    <= cnt_next;
      resume_reg <= resume_next;
      gate_reg   <= gate_next;
    end
  end

  assign gate     = gate_reg;
  assign resume   = resume_reg;
  assign sleeping = state_reg != SLC_ACTIVE;

  AST_ENTER: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ACTIVE && sleep_instr && sen_reg
    && sleep_mode_select_reg != SLC_MODE_RESERVED
    |=> state_reg == SLC_ASLEEP && mode_reg == $past(sleep_mode_select_reg))
    else $error("Sleep not entered");

  AST_SEN_CLEAR: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ACTIVE && sleep_instr && !sen_reg
    |=> state_reg == SLC_ACTIVE && gate.cpu_clk_en)
    else $error("Sleep entered with enable clear");

  AST_RESERVED: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ACTIVE && sleep_mode_select_reg == SLC_MODE_RESERVED
    |=> state_reg == SLC_ACTIVE)
    else $error("Reserved mode entered sleep");

  AST_BREAK_WAKE: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && dbg_break |=> state_reg != SLC_ASLEEP)
    else $error("Debug break did not wake");

  AST_NO_IRQ: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && !global_irq_en && !dbg_break
    |=> state_reg == SLC_ASLEEP)
    else $error("Woke without enabled interrupt");

  AST_POWER_DOWN_CODE_SOF: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_POWER_DOWN_CODE && !dbg_break
    && !wake_req.pin && !wake_req.twi_match && !wake_req.periodic_interrupt_timer
    |=> state_reg == SLC_ASLEEP)
    else $error("Power-down woke on wrong source");

  AST_IDLE_LAT: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_IDLE && wake
    && brownout_config_fuse != SLC_BOD_WAIT_CODE
    |=> (state_reg == SLC_LATENCY && !resume) [*6] ##1 resume)
    else $error("Idle wake latency not six cycles");

  AST_BOD_HOLD: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_LATENCY && cnt_reg == 3'h0 && !bod_sync_reg
    && brownout_config_fuse == SLC_BOD_WAIT_CODE
    |=> state_reg == SLC_LATENCY && !resume)
    else $error("Resumed before brown-out ready");

  AST_POWER_DOWN_CODE_GATES: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_POWER_DOWN_CODE
    |-> !gate.per_clk_en && !gate.main_osc_en && gate.pit_clk_en
        && gate.wdt_clk_en && !gate.cpu_clk_en)
    else $error("Power-down gating wrong");

  AST_IDLE_GATES: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_IDLE
    |-> !gate.cpu_clk_en && gate.per_clk_en && gate.main_osc_en)
    else $error("Idle gating wrong");

  AST_STBY_ADC: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && $past(state_reg) == SLC_ASLEEP
    && mode_reg == SLC_MODE_STANDBY
    |-> gate.adc_clk_en == $past(run_in_standby.adc))
    else $error("Standby converter gating wrong");

  // Peripheral clock in standby follows the usart and adc run-in-standby settings
  AST_STBY_PER: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && $past(state_reg) == SLC_ASLEEP
    && mode_reg == SLC_MODE_STANDBY
    |-> gate.per_clk_en
        == $past(run_in_standby.usart | run_in_standby.adc))
    else $error("Standby peripheral gating wrong");

  // Type B timer wakes from standby without a run-in-standby condition
  AST_STBY_TCB: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_STANDBY
    && global_irq_en && wake_req.type_b_timer
    |=> state_reg == SLC_OSC_WAIT)
    else $error("Standby did not wake on timer");

  // Start-of-frame alone must not wake a standby with the serial unit off
  AST_STBY_SOF: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_STANDBY && !dbg_break
    && !run_in_standby.usart && 8'(wake_req) == 8'h20
    |=> state_reg == SLC_ASLEEP)
    else $error("Standby woke on gated source");

  // Pin change wakes from power-down
  AST_POWER_DOWN_CODE_PIN: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_POWER_DOWN_CODE
    && global_irq_en && wake_req.pin
    |=> state_reg == SLC_OSC_WAIT)
    else $error("Power-down did not wake on pin");

  // No latency count starts before the oscillator is stable
  AST_OSC_WAIT: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_OSC_WAIT && !osc_sync_reg |=> state_reg == SLC_OSC_WAIT)
    else $error("Left oscillator wait early");

  // Latency counter steps down by one each cycle
  AST_LAT_STEP: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_LATENCY && cnt_reg != 3'h0
    |=> state_reg == SLC_LATENCY && cnt_reg == $past(cnt_reg) - 3'h1)
    else $error("Latency count skipped");

  // Resume is a single-cycle pulse
  AST_RESUME_ONE: assert property (@(posedge clk) disable iff (!resetn)
    resume |=> !resume)
    else $error("Resume pulse too long");

  CVR_IDLE: cover property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && mode_reg == SLC_MODE_IDLE ##[1:50] resume);
  CVR_POWER_DOWN_CODE: cover property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_OSC_WAIT && mode_reg == SLC_MODE_POWER_DOWN_CODE ##[1:50] resume);
  CVR_BREAK: cover property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_ASLEEP && dbg_break && !global_irq_en);
  CVR_STBY: cover property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_OSC_WAIT && mode_reg == SLC_MODE_STANDBY
    ##[1:50] resume);
  CVR_BOD: cover property (@(posedge clk) disable iff (!resetn)
    state_reg == SLC_LATENCY && cnt_reg == 3'h0 && !bod_sync_reg);
endmodule
`default_nettype wire

// file: verification/slc_core_model.sv
// Core and main oscillator model facing the sleep controller
`default_nettype none
module slc_core_model
  import slc_pkg::*;
#(
  parameter int OSC_CYC = 5
)
(
  input  wire logic      clk,
  input  wire logic      resetn,
  input  wire logic      do_sleep,
  input  wire slc_gate_s gate,
  output logic           sleep_instr,
  output logic           main_osc_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Sleep pulse only while the core is clocked; ready after start-up
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sleep_instr    <= 1'b0;
      cnt            <= 0;
      main_osc_ready <= 1'b0;
    end else begin
      sleep_instr <= do_sleep & gate.cpu_clk_en & !sleep_instr;
      if (!gate.main_osc_en) begin
        cnt <= 0;
      end else if (cnt < OSC_CYC) begin
        cnt <= cnt + 1;
      end
      main_osc_ready <= gate.main_osc_en && cnt >= OSC_CYC;
    end
  end
endmodule
`default_nettype wire

// file: verification/tb_top.sv
// Self-checking bench for the sleep controller
`default_nettype none
module tb_top
  import slc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OSC  = 5;
  localparam int BASE = SLC_WAKE_CYCLES;
  logic        clk;
  logic        resetn = 1'b0;
  logic [3:0]  adr = 4'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdq;
  logic [31:0] rdat;
  logic        wt;
  logic        gie = 1'b0;
  logic        dbg = 1'b0;
  logic        bodr = 1'b1;
  logic        dos = 1'b0;
  logic [1:0]  fuse = 2'h0;
  slc_wake_s   wk = '0;
  slc_rsb_s    rsb = '0;
  slc_gate_s   gate;
  logic        sl;
  logic        rs;
  logic        si;
  logic        mor;
  int          err_total = 0;
  int          comparisons = 0;
  int          ni;
  int          n;

  slc_sleep_controller dut (
    .clk(clk), .resetn(resetn), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_byteenable(4'hf),
    .avs_readdata(rdq), .avs_waitrequest(wt), .sleep_instr(si),
    .global_irq_en(gie), .wake_req(wk), .run_in_standby(rsb),
    .dbg_break(dbg), .brownout_config_fuse(fuse),
    .bod_uses_ulp(1'b1), .wdt_uses_ulp(1'b0), .main_osc_ready(mor),
    .brownout_ready(bodr), .gate(gate), .sleeping(sl), .resume(rs));

  slc_core_model #(.OSC_CYC(OSC)) core (
    .clk(clk), .resetn(resetn), .do_sleep(dos), .gate(gate),
    .sleep_instr(si), .main_osc_ready(mor));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic print_verdict();
    if (err_total == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge clk);
    adr <= a;
    wd  <= d;
    rd  <= !w;
    wr  <= w;
    i = 0;
    do begin
      @(posedge clk);
      #1;
      i++;
    end while (wt !== 1'b0 && i < 50);
    if (i >= 50) begin
      err_total++;
      print_verdict();
    end
    rdat = rdq;
    @(posedge clk);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  // Arm the register, then let the core issue one sleep instruction
  task automatic nap(input logic [1:0] m, input logic en);
    @(posedge clk);
    wk <= '0;
    bus(1'b1, SLC_CTRL_OFFSET, {29'h0, m, en});
    @(posedge clk);
    dos <= 1'b1;
    @(posedge clk);
    dos <= 1'b0;
    cyc(3);
  endtask

  task automatic wake(input logic [7:0] w, output int k);
    @(posedge clk);
    wk <= w;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (rs !== 1'b1 && k < 300);
    if (k >= 300) begin
      err_total++;
      print_verdict();
    end
  endtask

  // Offer requests that must not end sleep
  task automatic hold(input logic [7:0] w);
    @(posedge clk);
    wk <= w;
    cyc(20);
    chk(sl, 1'b1);
  endtask

  task automatic s_reg();
    bus(1'b0, SLC_CTRL_OFFSET, 32'h0);
    chk(rdat, {24'h0, SLC_CTRL_RESET});
    bus(1'b1, SLC_CTRL_OFFSET, 32'hffff_ffff);
    bus(1'b0, SLC_CTRL_OFFSET, 32'h0);
    chk(rdat, 32'h0000_0007);
    bus(1'b0, 4'h4, 32'h0);
    chk(rdat, 32'h0);
  endtask

  task automatic s_refuse();
    nap(SLC_MODE_IDLE, 1'b0);
    chk(sl, 1'b0);
    chk(gate, 10'h3ff);
    nap(SLC_MODE_RESERVED, 1'b1);
    chk(sl, 1'b0);
  endtask

  task automatic s_idle();
    @(posedge clk);
    gie <= 1'b1;
    nap(SLC_MODE_IDLE, 1'b1);
    chk(gate, 10'h1ff);
    wake(8'h01, ni);
    chk(ni >= BASE + 1 && ni <= BASE + 2, 1'b1);
    chk(sl, 1'b0);
    bus(1'b0, SLC_CTRL_OFFSET, 32'h0);
    chk(rdat, 32'h0000_0001);
  endtask

  task automatic s_stby();
    @(posedge clk);
    rsb <= 3'h1;
    nap(SLC_MODE_STANDBY, 1'b1);
    chk(gate[9:1], 9'h05b);
    hold(8'h20);
    wake(8'h02, n);
    chk(n >= ni + OSC + 2 && n <= ni + OSC + 5, 1'b1);
  endtask

  task automatic s_power_down_code();
    nap(SLC_MODE_POWER_DOWN_CODE, 1'b1);
    chk(gate, 10'h037);
    hold(8'h3b);
    @(posedge clk);
    gie <= 1'b0;
    hold(8'h80);
    @(posedge clk);
    gie <= 1'b1;
    wake(8'h80, n);
    chk(n >= ni + OSC + 2 && n <= ni + OSC + 5, 1'b1);
  endtask

  task automatic s_dbg();
    @(posedge clk);
    gie <= 1'b0;
    nap(SLC_MODE_IDLE, 1'b1);
    @(posedge clk);
    dbg <= 1'b1;
    wake(8'h00, n);
    chk(n >= BASE && n <= BASE + 2, 1'b1);
    @(posedge clk);
    dbg <= 1'b0;
    gie <= 1'b1;
  endtask

  task automatic s_bod();
    @(posedge clk);
    fuse <= 2'h3;
    bodr <= 1'b0;
    nap(SLC_MODE_IDLE, 1'b1);
    hold(8'h01);
    @(posedge clk);
    bodr <= 1'b1;
    wake(8'h01, n);
    chk(n >= 2 && n <= 5, 1'b1);
  endtask

  task automatic s_rst();
    nap(SLC_MODE_POWER_DOWN_CODE, 1'b1);
    @(posedge clk);
    resetn <= 1'b0;
    cyc(2);
    chk(sl, 1'b0);
    chk(gate, 10'h3ff);
    @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, SLC_CTRL_OFFSET, 32'h0);
    chk(rdat, 32'h0);
  endtask

  initial begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    s_reg();
    s_refuse();
    s_idle();
    s_stby();
    s_power_down_code();
    s_dbg();
    s_bod();
    s_rst();
    print_verdict();
  end
endmodule
`default_nettype wire
